// File: logic/bor_regs.sv
// Brownout interrupt-enable and status registers behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module bor_regs (
  // Clock and resets
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        por_n,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Comparators, high while supply above threshold
  input  wire logic        io_comparator_raw,
  input  wire logic        core_comparator_raw,
  // Neighbouring sources
  input  wire logic        hf_osc_ready,
  input  wire logic        osc_fail_event,
  input  wire logic        adc_overrun_event,
  input  wire logic        adc_ready_event,
  // Core interrupt controller gating
  input  wire logic        global_irq_enable,
  input  wire logic        group_irq_mask,
  // Threshold selects to comparators, and monitor enables
  output logic [1:0]       io_irq_threshold,
  output logic [1:0]       core_irq_threshold,
  output logic             io_monitor_en,
  output logic             core_monitor_en,
  // Interrupt requests
  output logic             io_brownout_req,
  output logic             core_brownout_req,
  output logic             brownout_irq
);
  // Register state
  logic [15:0] analog_irq_enable, next_analog_irq_enable;
  logic [15:0] analog_power_enable, next_analog_power_enable;
  logic [15:0] voltage_monitor_ctrl, next_voltage_monitor_ctrl;
  logic        io_brownout_flag, next_io_brownout_flag;
  logic        core_brownout_flag, next_core_brownout_flag;
  logic        osc_fail_flag, next_osc_fail_flag;
  logic        adc_overrun_flag, next_adc_overrun_flag;
  logic        adc_ready_flag, next_adc_ready_flag;
  logic        io_sync, core_sync;
  logic        io_sync_d, next_io_sync_d;
  logic        core_sync_d, next_core_sync_d;
  logic        io_comparator_level;
  logic        core_comparator_level;
  logic        io_fall, core_fall;
  logic        status_read;
  // Bus state
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        do_write;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] status_word;

  // Comparator synchronisers
  bor_sync u_sync_io (
    .aclk    (aclk),
    .aresetn (por_n),
    .din     (io_comparator_raw),
    .dout    (io_sync)
  );
  bor_sync u_sync_core (
    .aclk    (aclk),
    .aresetn (por_n),
    .din     (core_comparator_raw),
    .dout    (core_sync)
  );

  // Levels, edges and requests
  assign io_monitor_en         = analog_power_enable[bor_pkg::BIT_IO_MON_EN];
  assign core_monitor_en       = analog_power_enable[bor_pkg::BIT_CORE_MON_EN];
  assign io_comparator_level   = io_sync & io_monitor_en;
  assign core_comparator_level = core_sync & core_monitor_en;
  assign io_fall               = io_sync_d & ~io_sync & io_monitor_en;
  assign core_fall             = core_sync_d & ~core_sync & core_monitor_en;
  assign io_irq_threshold      = voltage_monitor_ctrl[bor_pkg::BIT_IO_THR_LO +: 2];
  assign core_irq_threshold    = voltage_monitor_ctrl[bor_pkg::BIT_CORE_THR_LO +: 2];
  assign io_brownout_req       = analog_irq_enable[bor_pkg::BIT_IO_BO_EN] & io_brownout_flag;
  assign core_brownout_req     = analog_irq_enable[bor_pkg::BIT_CORE_BO_EN] & core_brownout_flag;
  // Gating is the processor's; modelled here so one line shows the taken request
  assign brownout_irq = (io_brownout_req | core_brownout_req) & global_irq_enable & group_irq_mask;

  // Status word assembly; unlisted bits stay zero
  always_comb begin
    status_word = 16'h0000;
    status_word[bor_pkg::BIT_IO_LEVEL]   = io_comparator_level;
    status_word[bor_pkg::BIT_CORE_LEVEL] = core_comparator_level;
    status_word[bor_pkg::BIT_OSC_READY]  = hf_osc_ready;
    status_word[bor_pkg::BIT_OSC_FAIL]   = osc_fail_flag;
    status_word[bor_pkg::BIT_IO_FLAG]    = io_brownout_flag;
    status_word[bor_pkg::BIT_CORE_FLAG]  = core_brownout_flag;
    status_word[bor_pkg::BIT_ADC_OVR]    = adc_overrun_flag;
    status_word[bor_pkg::BIT_ADC_READY]  = adc_ready_flag;
  end

  // Bus next state: capture AW and W in any order, answer after both
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    status_read  = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      // Status is read-only, so a write there is refused
      if (aw_addr == bor_pkg::ADDR_IRQ_ENABLE || aw_addr == bor_pkg::ADDR_POWER_ENABLE ||
          aw_addr == bor_pkg::ADDR_MONITOR_CTRL) begin
        next_bresp = bor_pkg::RESP_OKAY;
      end else begin
        next_bresp = bor_pkg::RESP_SLVERR;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = bor_pkg::RESP_OKAY;
      next_rdata  = 32'h00000000;
      case (s_axi_araddr)
        bor_pkg::ADDR_IRQ_ENABLE:   next_rdata[15:0] = analog_irq_enable;
        bor_pkg::ADDR_POWER_ENABLE: next_rdata[15:0] = analog_power_enable;
        bor_pkg::ADDR_MONITOR_CTRL: next_rdata[15:0] = voltage_monitor_ctrl;
        bor_pkg::ADDR_STATUS: begin
          next_rdata[15:0] = status_word;
          status_read      = 1'b1;
        end
        default: next_rresp = bor_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Handshake readies; one outstanding read, and a second write can be taken while a write response waits
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Write strobes expanded to the low 16 bits
  assign wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wval  = w_data[15:0];

  // Register and flag next values
  always_comb begin
    next_analog_irq_enable    = analog_irq_enable;
    next_analog_power_enable  = analog_power_enable;
    next_voltage_monitor_ctrl = voltage_monitor_ctrl;
    if (do_write && aw_addr == bor_pkg::ADDR_IRQ_ENABLE) begin
      // Only implemented bits take writes
      next_analog_irq_enable = (analog_irq_enable & ~(wmask & bor_pkg::IRQ_ENABLE_MASK)) |
                               (wval & wmask & bor_pkg::IRQ_ENABLE_MASK);
    end
    if (do_write && aw_addr == bor_pkg::ADDR_POWER_ENABLE) begin
      next_analog_power_enable = (analog_power_enable & ~(wmask & bor_pkg::POWER_ENABLE_MASK)) |
                                 (wval & wmask & bor_pkg::POWER_ENABLE_MASK);
    end
    if (do_write && aw_addr == bor_pkg::ADDR_MONITOR_CTRL) begin
      next_voltage_monitor_ctrl = (voltage_monitor_ctrl & ~(wmask & bor_pkg::MONITOR_CTRL_MASK)) |
                                  (wval & wmask & bor_pkg::MONITOR_CTRL_MASK);
    end
    // Set beats clear so a coincident event survives the read
    next_io_brownout_flag   = io_fall | (io_brownout_flag & ~status_read);
    next_core_brownout_flag = core_fall | (core_brownout_flag & ~status_read);
    next_osc_fail_flag      = osc_fail_event | (osc_fail_flag & ~status_read);
    next_adc_overrun_flag   = adc_overrun_event | (adc_overrun_flag & ~status_read);
    next_adc_ready_flag     = adc_ready_event | (adc_ready_flag & ~status_read);
    next_io_sync_d          = io_sync;
    next_core_sync_d        = core_sync;
  end

  // Bus and control registers and the ADC overrun flag, cleared by the warm reset aresetn only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held              <= 1'b0;
      w_held               <= 1'b0;
      aw_addr              <= 12'h000;
      w_data               <= 32'h00000000;
      w_strb               <= 4'h0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= bor_pkg::RESP_OKAY;
      s_axi_rvalid         <= 1'b0;
      s_axi_rdata          <= 32'h00000000;
      s_axi_rresp          <= bor_pkg::RESP_OKAY;
      analog_irq_enable    <= bor_pkg::IRQ_ENABLE_RESET;
      analog_power_enable  <= bor_pkg::POWER_ENABLE_RESET;
      voltage_monitor_ctrl <= bor_pkg::MONITOR_CTRL_RESET;
      adc_overrun_flag     <= 1'b0;
    end else begin
      aw_held              <= next_aw_held;
      w_held               <= next_w_held;
      aw_addr              <= next_aw_addr;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      s_axi_bvalid         <= next_bvalid;
      s_axi_bresp          <= next_bresp;
      s_axi_rvalid         <= next_rvalid;
      s_axi_rdata          <= next_rdata;
      s_axi_rresp          <= next_rresp;
      analog_irq_enable    <= next_analog_irq_enable;
      analog_power_enable  <= next_analog_power_enable;
      voltage_monitor_ctrl <= next_voltage_monitor_ctrl;
      adc_overrun_flag     <= next_adc_overrun_flag;
    end
  end

  // Status flags other than the ADC overrun flag survive warm resets; only power-on clears them
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      io_brownout_flag   <= 1'b0;
      core_brownout_flag <= 1'b0;
      osc_fail_flag      <= 1'b0;
      adc_ready_flag     <= 1'b0;
      io_sync_d          <= 1'b0;
      core_sync_d        <= 1'b0;
    end else begin
      io_brownout_flag   <= next_io_brownout_flag;
      core_brownout_flag <= next_core_brownout_flag;
      osc_fail_flag      <= next_osc_fail_flag;
      adc_ready_flag     <= next_adc_ready_flag;
      io_sync_d          <= next_io_sync_d;
      core_sync_d        <= next_core_sync_d;
    end
  end

  // Checks
  chk_io_request: assert property (@(posedge aclk) disable iff (!aresetn)
    io_brownout_req == (analog_irq_enable[bor_pkg::BIT_IO_BO_EN] && io_brownout_flag))
    else $error("io request mismatch");
  chk_core_request: assert property (@(posedge aclk) disable iff (!aresetn)
    core_brownout_req == (analog_irq_enable[bor_pkg::BIT_CORE_BO_EN] && core_brownout_flag))
    else $error("core request mismatch");
  chk_irq_gating: assert property (@(posedge aclk) disable iff (!aresetn)
    brownout_irq |-> (global_irq_enable && group_irq_mask))
    else $error("irq without gating");
  chk_enable_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    (analog_irq_enable & ~bor_pkg::IRQ_ENABLE_MASK) == 16'h0000)
    else $error("reserved enable bit set");
  chk_status_clear: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    (status_read && !io_fall) |=> !io_brownout_flag)
    else $error("io flag not cleared by read");
  chk_io_flag_set: assert property (@(posedge aclk) disable iff (!por_n)
    io_fall |=> io_brownout_flag)
    else $error("io event lost");
  chk_core_flag_set: assert property (@(posedge aclk) disable iff (!por_n)
    core_fall |=> core_brownout_flag)
    else $error("core event lost");
  chk_io_level_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !io_monitor_en |-> !status_word[bor_pkg::BIT_IO_LEVEL])
    else $error("io level shown while off");
  chk_core_level_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !core_monitor_en |-> !status_word[bor_pkg::BIT_CORE_LEVEL])
    else $error("core level shown while off");
  chk_flag_hold: assert property (@(posedge aclk) disable iff (!por_n)
    (io_brownout_flag && !status_read) |=> io_brownout_flag)
    else $error("io flag dropped without read");
endmodule // bor_regs

// File: logic/bor_pkg.sv
// Package: register map, field positions and reset values for the brownout status block
package bor_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_IRQ_ENABLE   = 8'h0a;
  localparam logic [7:0]  IDX_STATUS       = 8'h0b;
  localparam logic [7:0]  IDX_POWER_ENABLE = 8'h05;
  localparam logic [7:0]  IDX_MONITOR_CTRL = 8'h06;
  localparam logic [11:0] ADDR_IRQ_ENABLE   = {2'h0, IDX_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_STATUS       = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_POWER_ENABLE = {2'h0, IDX_POWER_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_MONITOR_CTRL = {2'h0, IDX_MONITOR_CTRL, 2'h0};
  localparam int          ADDR_W            = 12;
  // Interrupt-enable fields
  localparam int BIT_USER_SW      = 0;
  localparam int BIT_ADC_READY_EN = 1;
  localparam int BIT_ADC_OVR_EN   = 2;
  localparam int BIT_CORE_BO_EN   = 4;
  localparam int BIT_IO_BO_EN     = 5;
  localparam int BIT_OSC_FAIL_EN  = 6;
  localparam logic [15:0] IRQ_ENABLE_MASK  = 16'h0077;
  localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0001;
  // Status fields
  localparam int BIT_ADC_READY  = 1;
  localparam int BIT_ADC_OVR    = 2;
  localparam int BIT_CORE_FLAG  = 4;
  localparam int BIT_IO_FLAG    = 5;
  localparam int BIT_OSC_FAIL   = 6;
  localparam int BIT_OSC_READY  = 11;
  localparam int BIT_CORE_LEVEL = 14;
  localparam int BIT_IO_LEVEL   = 15;
  // Power-enable fields (monitor enables only)
  localparam int BIT_CORE_MON_EN = 11;
  localparam int BIT_IO_MON_EN   = 12;
  localparam logic [15:0] POWER_ENABLE_MASK  = 16'h1800;
  localparam logic [15:0] POWER_ENABLE_RESET = 16'h0000;
  // Monitor control fields
  localparam int BIT_CORE_THR_LO = 2;
  localparam int BIT_IO_THR_LO   = 4;
  localparam logic [15:0] MONITOR_CTRL_MASK  = 16'h003c;
  localparam logic [15:0] MONITOR_CTRL_RESET = 16'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: logic/bor_sync.sv
// Two-stage synchroniser for one comparator level
`timescale 1ns/1ps
module bor_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  logic stage1;
  logic next_stage1;
  logic next_dout;

  // Next values; first stage feeds only the second
  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule // bor_sync

// File: sim/bor_comp_model.sv
// Behavioural model of the two supply brownout comparators
`timescale 1ns/1ps
module bor_comp_model (
  // Supply codes from the bench, a larger code is a higher voltage
  input  wire logic [2:0] io_supply,
  input  wire logic [2:0] core_supply,
  // Threshold selects from the block
  input  wire logic [1:0] io_irq_threshold,
  input  wire logic [1:0] core_irq_threshold,
  // Asynchronous comparator outputs
  output logic            io_comparator_raw,
  output logic            core_comparator_raw
);
  // Output ignores the monitor enable, so the block must gate it itself
  // Analog delay keeps edges away from the clock
  assign #7 io_comparator_raw   = io_supply > {1'b0, io_irq_threshold};
  assign #7 core_comparator_raw = core_supply > {1'b0, core_irq_threshold};
endmodule // bor_comp_model

// File: sim/tb_top.sv
// Self-checking testbench for the brownout interrupt-enable and status registers
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn, por_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, io_irq_threshold, core_irq_threshold, rsp, ti, tc;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        io_comparator_raw, core_comparator_raw, hf_osc_ready, osc_fail_event;
  logic        adc_overrun_event, adc_ready_event, global_irq_enable, group_irq_mask;
  logic        io_monitor_en, core_monitor_en, io_brownout_req, core_brownout_req, brownout_irq;
  logic [2:0]  io_supply, core_supply;
  logic [15:0] d16;
  int          n_errors, num_checks;

  // Design and comparator model
  bor_regs uut (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .io_comparator_raw, .core_comparator_raw, .hf_osc_ready, .osc_fail_event, .adc_overrun_event,
    .adc_ready_event, .global_irq_enable, .group_irq_mask, .io_irq_threshold, .core_irq_threshold,
    .io_monitor_en, .core_monitor_en, .io_brownout_req, .core_brownout_req, .brownout_irq);
  bor_comp_model comp (.io_supply, .core_supply, .io_irq_threshold, .core_irq_threshold,
    .io_comparator_raw, .core_comparator_raw);

  // 25 MHz clock
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  // Expected status word, built bit by bit from the field layout
  function automatic logic [31:0] st(input logic iol, col, osr, ofl, iof, cof, ovr, ard);
    st = {16'h0000, iol, col, 2'b00, osr, 4'h0, ofl, iof, cof, 1'b0, ovr, ard, 1'b0};
  endfunction
  // Expected enable readback: only bits 6..4 and 2..0 hold
  function automatic logic [31:0] en(input logic [15:0] d);
    en = {16'h0000, 9'h000, d[6:4], 1'b0, d[2:0]};
  endfunction

  // Count a compare, report a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Settle point half a cycle after the edge
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  // Write one word; each channel released at the edge that takes it
  task automatic axw(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
    bit ga, gw, gb;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    forever begin
      @(negedge aclk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid && s_axi_bready;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      if (gb) break;
    end
    s_axi_bready <= 1'b0;
  endtask
  // Read one word; inputs are stable from the falling edge to the taking edge
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ga, gr;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(negedge aclk);
      ga = s_axi_arvalid && s_axi_arready;
      gr = s_axi_rvalid && s_axi_rready;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ga) s_axi_arvalid <= 1'b0;
      if (gr) break;
    end
    s_axi_rready <= 1'b0;
  endtask
  // Read and compare data and an okay response
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string m);
    axr(a, rd, rsp);
    chk(rd, e, m);
    chk({30'h0, rsp}, {30'h0, bor_pkg::RESP_OKAY}, "read resp");
  endtask
  // One-cycle pulse on the neighbouring event inputs
  task automatic pulse_ev;
    @(posedge aclk);
    {osc_fail_event, adc_overrun_event, adc_ready_event} <= 3'h7;
    @(posedge aclk);
    {osc_fail_event, adc_overrun_event, adc_ready_event} <= 3'h0;
    cyc(3);
  endtask
  // Verdict, reached from the main sequence or the watchdog
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("BAD %0t watchdog", $time);
    stop_test;
  end

  // Main sequence
  initial begin
    {aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {hf_osc_ready, osc_fail_event, adc_overrun_event, adc_ready_event} = 4'h0;
    {global_irq_enable, group_irq_mask} = 2'h3;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata  = 32'h0;
    s_axi_wstrb  = 4'hf;
    io_supply    = 3'h7;
    core_supply  = 3'h7;
    void'($urandom(32'h8f27));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    por_n   <= 1'b1;
    cyc(1);
    chk({28'h0, io_irq_threshold, core_irq_threshold}, 32'h0, "thr reset");
    rchk(bor_pkg::ADDR_IRQ_ENABLE, en(16'h0001), "enable reset");
    rchk(bor_pkg::ADDR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0), "status reset");
    axr(12'h100, rd, rsp);
    chk({rd[31:2], rsp}, {30'h0, bor_pkg::RESP_SLVERR}, "unmapped read");
    axw(12'h100, 16'hffff, rsp);
    chk({30'h0, rsp}, {30'h0, bor_pkg::RESP_SLVERR}, "unmapped write");
    axw(bor_pkg::ADDR_STATUS, 16'hffff, rsp);
    chk({30'h0, rsp}, {30'h0, bor_pkg::RESP_SLVERR}, "status write");
    rchk(bor_pkg::ADDR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0), "status after write");
    // Enable register: all ones, all zeros, then random words
    for (int i = 0; i < 8; i++) begin
      d16 = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      axw(bor_pkg::ADDR_IRQ_ENABLE, d16, rsp);
      rchk(bor_pkg::ADDR_IRQ_ENABLE, en(d16), "enable rw");
    end
    // Random thresholds; supplies fall while the monitors are still off
    ti = 2'($urandom);
    tc = 2'($urandom);
    axw(bor_pkg::ADDR_MONITOR_CTRL, {10'h000, ti, tc, 2'h0}, rsp);
    cyc(1);
    chk({28'h0, io_irq_threshold, core_irq_threshold}, {28'h0, ti, tc}, "thr select");
    @(posedge aclk);
    io_supply   <= 3'(ti);
    core_supply <= 3'(tc);
    cyc(6);
    rchk(bor_pkg::ADDR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0), "monitors off");
    @(posedge aclk);
    io_supply   <= 3'(ti) + 3'(1 + $urandom % 3);
    core_supply <= 3'(tc) + 3'(1 + $urandom % 3);
    axw(bor_pkg::ADDR_POWER_ENABLE, 16'h1800, rsp);
    axw(bor_pkg::ADDR_IRQ_ENABLE, 16'h0030, rsp);
    cyc(6);
    chk({30'h0, io_monitor_en, core_monitor_en}, 32'h3, "monitor enables");
    rchk(bor_pkg::ADDR_STATUS, st(1, 1, 0, 0, 0, 0, 0, 0), "levels high");
    // I/O supply falls: flag, request and gated interrupt
    @(posedge aclk);
    io_supply <= 3'(ti);
    cyc(6);
    chk({30'h0, io_brownout_req, core_brownout_req}, 32'h2, "io request");
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      {group_irq_mask, global_irq_enable} <= 2'(k);
      cyc(1);
      chk({31'h0, brownout_irq}, 32'(k == 3), "irq gating");
    end
    @(posedge aclk);
    core_supply <= 3'(tc);
    cyc(6);
    chk({31'h0, core_brownout_req}, 32'h1, "core request");
    axw(bor_pkg::ADDR_IRQ_ENABLE, 16'h0020, rsp);
    cyc(1);
    chk({30'h0, io_brownout_req, core_brownout_req}, 32'h2, "core disabled");
    axw(bor_pkg::ADDR_IRQ_ENABLE, 16'h0000, rsp);
    cyc(1);
    chk({30'h0, io_brownout_req, core_brownout_req}, 32'h0, "io disabled");
    // I/O supply recovers; read clears flags but not the level
    @(posedge aclk);
    io_supply <= 3'h7;
    cyc(6);
    rchk(bor_pkg::ADDR_STATUS, st(1, 0, 0, 0, 1, 1, 0, 0), "flags set");
    rchk(bor_pkg::ADDR_STATUS, st(1, 0, 0, 0, 0, 0, 0, 0), "flags cleared");
    // Neighbouring sources, then a warm reset alone
    @(posedge aclk);
    hf_osc_ready <= 1'b1;
    pulse_ev;
    rchk(bor_pkg::ADDR_STATUS, st(1, 0, 1, 1, 0, 0, 1, 1), "neighbours");
    // Event high only at the edge that takes the read: the set must survive
    fork
      rchk(bor_pkg::ADDR_STATUS, st(1, 0, 1, 0, 0, 0, 0, 0), "read with event");
      begin
        @(posedge aclk);
        osc_fail_event <= 1'b1;
        @(posedge aclk);
        osc_fail_event <= 1'b0;
      end
    join
    rchk(bor_pkg::ADDR_STATUS, st(1, 0, 1, 1, 0, 0, 0, 0), "set beats read");
    pulse_ev;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(bor_pkg::ADDR_STATUS, st(0, 0, 1, 1, 0, 0, 0, 1), "warm reset");
    rchk(bor_pkg::ADDR_IRQ_ENABLE, en(16'h0001), "enable warm");
    stop_test;
  end
endmodule // tb_top
